// ===== common/bad_pkg.sv
// Package for the board address decode block: map constants, config fields, carrier structs.
// Assumes a single 10 MHz clock domain and an APB register slave in the top module.
package bad_pkg;

  // APB register byte addresses
  localparam logic [11:0] REG_MAP_CFG   = 12'h000;
  localparam logic [11:0] REG_STATUS    = 12'h004;
  localparam logic [11:0] REG_LAST_ADDR = 12'h008;

  // Map configuration field layout
  localparam int MAP_BLK0_LSB  = 0;
  localparam int MAP_BLK1_LSB  = 2;
  localparam int MAP_BLK2_LSB  = 4;
  localparam int MAP_TRAP_LSB  = 6;
  localparam int MAP_ROMSZ_LSB = 8;
  localparam int MAP_EN_LSB    = 12;
  localparam logic [31:0] MAP_CFG_RESET = 32'h0000_0024;

  // Upper nibble codes
  localparam logic [3:0] NIB_HOST  = 4'hA;
  localparam logic [3:0] NIB_PIO   = 4'hB;
  localparam logic [3:0] NIB_TRLO  = 4'hC;
  localparam logic [3:0] NIB_TRHI  = 4'hD;
  localparam logic [3:0] NIB_FWLO  = 4'hE;
  localparam logic [3:0] NIB_FWHI  = 4'hF;

  // Injected opcode
  localparam logic [7:0] NOOP_OPCODE = 8'h00;

  typedef enum logic [1:0] {
    BAD_ROM_1K = 2'b00,
    BAD_ROM_2K = 2'b01,
    BAD_ROM_4K = 2'b10
  } bad_rom_size_t;

  typedef struct packed {
    logic ale;
    logic rd_n;
    logic wr_n;
    logic psen_n;
    logic inject_noop;
  } bad_strobe_t;

  typedef struct packed {
    logic host_ctrl_sel_n;
    logic pio_sel_n;
    logic trap_ram_lo_sel_n;
    logic trap_ram_hi_sel_n;
    logic firmware_lo_sel_n;
    logic firmware_hi_sel_n;
    logic user_blk0_sel_n;
    logic user_blk1_sel_n;
    logic user_blk2_sel_n;
  } bad_sel_t;

endpackage

// ===== verilog/bad_decode.sv
// Address demultiplex and decode for the processor's multiplexed bus, with APB config.
// Assumes processor strobes already sampled into ref_clk; pads are split in/out/enable.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module bad_decode (
  // Clock and reset
  input  wire  logic               ref_clk,
  input  wire  logic               reset,
  // APB slave
  input  wire  logic               psel,
  input  wire  logic               penable,
  input  wire  logic               pwrite,
  input  wire  logic [11:0]        paddr,
  input  wire  logic [31:0]        pwdata,
  output logic       [31:0]        prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Processor bus
  input  wire  bad_pkg::bad_strobe_t strb,
  input  wire  logic [7:0]         ad_lo_in,
  input  wire  logic [7:0]         addr_hi,
  output logic       [7:0]         ad_lo_out,
  output logic                     ad_lo_oe,
  // Board bus
  input  wire  logic [7:0]         db_in,
  output logic       [7:0]         db_out,
  output logic                     db_oe,
  output logic       [15:0]        board_addr,
  // Selects and strobes
  output bad_pkg::bad_sel_t        sel,
  output logic       [7:0]         ram_seg_sel_n,
  output logic       [3:0]         rom_chip_sel_n,
  output logic                     sram_we_n,
  output logic                     trap_space_sel_n,
  output logic                     trap_ram_wr_n,
  output logic                     boot_overlay_n
);

  logic        ale_q;
  logic [15:0] addr_q;
  logic [31:0] map_q;
  logic        boot_q;
  logic        cfg_err_q;
  logic        cyc_q;
  logic [7:0]  db_out_q;
  logic [7:0]  ad_out_q;
  logic        db_oe_q;
  logic        ad_oe_q;
  logic        we_q;
  logic        trap_q;
  logic        twr_q;
  logic [7:0]  seg_q;
  logic [3:0]  rom_q;
  bad_pkg::bad_sel_t sel_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  function automatic logic [3:0] dec2(input logic [1:0] v);
    dec2 = 4'h1 << v;
  endfunction

  // Address latch on strobe fall
  wire        ale_fall   = ale_q & ~strb.ale;
  wire [15:0] cur_addr   = ale_fall ? {addr_hi, ad_lo_in} : addr_q;
  wire [3:0]  nib        = cur_addr[15:12];
  wire        cyc_act    = ~strb.rd_n | ~strb.wr_n | ~strb.psen_n;

  // Config fields
  wire [1:0]  blk0_sp    = map_q[bad_pkg::MAP_BLK0_LSB +: 2];
  wire [1:0]  blk1_sp    = map_q[bad_pkg::MAP_BLK1_LSB +: 2];
  wire [1:0]  blk2_sp    = map_q[bad_pkg::MAP_BLK2_LSB +: 2];
  wire [1:0]  trap_sp    = map_q[bad_pkg::MAP_TRAP_LSB +: 2];
  wire [1:0]  rom_sz     = map_q[bad_pkg::MAP_ROMSZ_LSB +: 2];
  wire [2:0]  blk_en     = map_q[bad_pkg::MAP_EN_LSB +: 3];
  // Overlapping map is refused: one space cannot serve two blocks
  wire        map_clash  = (blk0_sp == blk1_sp) | (blk0_sp == blk2_sp) | (blk1_sp == blk2_sp);

  // User space decode
  wire        user_en    = ~cur_addr[15];
  wire [3:0]  space_hot  = user_en ? dec2(cur_addr[14:13]) : 4'h0;
  wire [3:0]  space_ok   = {space_hot[3:1], space_hot[0] & boot_q};
  wire        map_ok     = ~map_clash;
  wire        blk0_hit   = blk_en[0] & map_ok & space_ok[blk0_sp];
  wire        blk1_hit   = blk_en[1] & map_ok & space_ok[blk1_sp];
  wire        blk2_hit   = blk_en[2] & map_ok & space_ok[blk2_sp];
  wire        trap_hit   = space_ok[trap_sp];

  // Upper decode; 8xxx/9xxx match nothing
  wire        host_hit   = nib == bad_pkg::NIB_HOST;
  wire        pio_hit    = nib == bad_pkg::NIB_PIO;
  wire        trlo_hit   = nib == bad_pkg::NIB_TRLO;
  wire        trhi_hit   = nib == bad_pkg::NIB_TRHI;
  // Reset fetch at 0000H lands in firmware low
  wire        fwlo_hit   = (nib == bad_pkg::NIB_FWLO) | (~boot_q & space_hot[0]);
  wire        fwhi_hit   = nib == bad_pkg::NIB_FWHI;

  // RAM segment and ROM chip decode
  wire [7:0]  seg_hot    = (blk0_hit | blk1_hit) ? (8'h01 << cur_addr[12:10]) : 8'h00;
  wire [1:0]  rom_idx    = (rom_sz == bad_pkg::BAD_ROM_4K) ? {1'b0, cur_addr[12]} :
                           (rom_sz == bad_pkg::BAD_ROM_2K) ? cur_addr[12:11] : cur_addr[11:10];
  // Beyond 3K/6K capacity the last chip index stays unselected
  wire        rom_cap    = (rom_sz == bad_pkg::BAD_ROM_1K) ? ~cur_addr[12] & (cur_addr[11:10] != 2'b11) :
                           (rom_sz == bad_pkg::BAD_ROM_2K) ? (cur_addr[12:11] != 2'b11) : 1'b1;
  wire [3:0]  rom_hot    = (blk2_hit & rom_cap) ? dec2(rom_idx) : 4'h0;

  // Data steering
  wire        buf_en     = cyc_act & ~pio_hit & ~strb.inject_noop;
  wire        to_board   = ~strb.wr_n;
  wire        trap_wr    = (trlo_hit | trhi_hit) & ~strb.wr_n;

  // A net, so each field may carry its own continuous assignment
  wire bad_pkg::bad_sel_t sel_d;
  assign sel_d.host_ctrl_sel_n   = ~host_hit;
  assign sel_d.pio_sel_n         = ~pio_hit;
  assign sel_d.trap_ram_lo_sel_n = ~trlo_hit;
  assign sel_d.trap_ram_hi_sel_n = ~trhi_hit;
  assign sel_d.firmware_lo_sel_n = ~fwlo_hit;
  assign sel_d.firmware_hi_sel_n = ~fwhi_hit;
  assign sel_d.user_blk0_sel_n   = ~blk0_hit;
  assign sel_d.user_blk1_sel_n   = ~blk1_hit;
  assign sel_d.user_blk2_sel_n   = ~blk2_hit;

  // APB decode
  wire        apb_acc    = psel & penable;
  wire        hit_cfg    = paddr == bad_pkg::REG_MAP_CFG;
  wire        hit_stat   = paddr == bad_pkg::REG_STATUS;
  wire        hit_addr   = paddr == bad_pkg::REG_LAST_ADDR;
  wire        apb_bad    = ~(hit_cfg | hit_stat | hit_addr);
  wire [31:0] rd_mux     = hit_cfg  ? map_q :
                           hit_stat ? {28'h0000000, cyc_q, cfg_err_q, map_clash, boot_q} :
                           hit_addr ? {16'h0000, addr_q} : 32'h0000_0000;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ale_q  <= 1'b0;
      addr_q <= 16'h0000;
    end else begin
      ale_q  <= strb.ale;
      addr_q <= cur_addr;
    end
  end

  // Overlay: low from reset until the first trap memory write
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      boot_q <= 1'b0;
    end else if (trap_wr) begin
      boot_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      map_q     <= bad_pkg::MAP_CFG_RESET;
      cfg_err_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & apb_bad;
      prdata_q  <= rd_mux;
      if (apb_acc & pready_q & pwrite & hit_cfg) begin
        map_q     <= pwdata;
        // Sticky note that software put blocks 0 and 1 in one space; is its duty
        cfg_err_q <= cfg_err_q | (pwdata[bad_pkg::MAP_BLK0_LSB +: 2] == pwdata[bad_pkg::MAP_BLK1_LSB +: 2]);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sel_q    <= '1;
      seg_q    <= 8'hFF;
      rom_q    <= 4'hF;
      we_q     <= 1'b1;
      trap_q   <= 1'b1;
      twr_q    <= 1'b1;
      db_oe_q  <= 1'b0;
      ad_oe_q  <= 1'b0;
      db_out_q <= 8'h00;
      ad_out_q <= 8'h00;
      cyc_q    <= 1'b0;
    end else begin
      sel_q    <= sel_d;
      seg_q    <= ~seg_hot;
      rom_q    <= ~rom_hot;
      we_q     <= strb.wr_n;
      trap_q   <= ~trap_hit;
      twr_q    <= ~trap_wr;
      cyc_q    <= cyc_act;
      db_oe_q  <= buf_en & to_board;
      ad_oe_q  <= (buf_en & ~to_board) | strb.inject_noop;
      db_out_q <= ad_lo_in;
      ad_out_q <= strb.inject_noop ? bad_pkg::NOOP_OPCODE : db_in;
    end
  end

  assign sel              = sel_q;
  assign ram_seg_sel_n    = seg_q;
  assign rom_chip_sel_n   = rom_q;
  assign sram_we_n        = we_q;
  assign trap_space_sel_n = trap_q;
  assign trap_ram_wr_n    = twr_q;
  assign boot_overlay_n   = boot_q;
  assign db_out           = db_out_q;
  assign db_oe            = db_oe_q;
  assign ad_lo_out        = ad_out_q;
  assign ad_lo_oe         = ad_oe_q;
  assign board_addr       = addr_q;
  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;

  chk_reserved_quiet: assert property (@(posedge ref_clk) disable iff (reset)
    $past(nib == 4'h8 || nib == 4'h9) |-> (sel == '1 && seg_q == 8'hFF && rom_q == 4'hF))
    else $error("select active in reserved range");

  chk_noop_drive: assert property (@(posedge ref_clk) disable iff (reset)
    strb.inject_noop |=> (ad_lo_oe && ad_lo_out == 8'h00 && !db_oe))
    else $error("noop opcode not driven");

  chk_pio_blocks_buf: assert property (@(posedge ref_clk) disable iff (reset)
    !sel.pio_sel_n |-> !db_oe || $past(!pio_hit))
    else $error("buffer open during parallel io");

  chk_overlay_release: assert property (@(posedge ref_clk) disable iff (reset)
    (trap_wr && !boot_q) |=> boot_overlay_n ##1 boot_overlay_n)
    else $error("overlay not released by trap write");

  chk_overlay_blocks: assert property (@(posedge ref_clk) disable iff (reset)
    (!boot_q && space_hot[0]) |=> (sel.user_blk0_sel_n && sel.user_blk1_sel_n && sel.user_blk2_sel_n
                                   && !sel.firmware_lo_sel_n))
    else $error("low user space reachable under overlay");

  chk_one_select: assert property (@(posedge ref_clk) disable iff (reset)
    $countones(~sel) <= 1)
    else $error("more than one select low");

  chk_host_nibble: assert property (@(posedge ref_clk) disable iff (reset)
    (nib == bad_pkg::NIB_HOST) |=> !sel.host_ctrl_sel_n && sel.pio_sel_n)
    else $error("host select wrong");

  chk_write_enable: assert property (@(posedge ref_clk) disable iff (reset)
    !strb.wr_n |=> !sram_we_n)
    else $error("ram write enable not low on write");

  chk_addr_hold: assert property (@(posedge ref_clk) disable iff (reset)
    (!ale_fall ##1 !ale_fall) |-> $stable(addr_q))
    else $error("address changed without strobe fall");

endmodule

`default_nettype wire

// ===== testbench/bad_cpu_model.sv
// Processor core model: drives the multiplexed address/data bus and strobes.
// Assumes the bench calls cycle() and checks outputs in the negedge it returns on.
`timescale 1ns/10ps
`default_nettype none
module bad_cpu_model (
  // Clock
  input  wire logic           ref_clk,
  // Processor bus
  output bad_pkg::bad_strobe_t strb,
  output logic [7:0]          ad_lo_in,
  output logic [7:0]          addr_hi
);
  initial begin
    strb = 5'b01110;
    ad_lo_in = 8'h00;
    addr_hi = 8'h00;
  end
  // Kind 0 read, 1 write, 2 fetch, 3 read with noop injection
  task automatic cycle(input logic [15:0] a, input logic [1:0] kind, input logic [7:0] d);
    @(posedge ref_clk);
    strb <= 5'b11110;
    addr_hi <= a[15:8];
    ad_lo_in <= a[7:0];
    @(posedge ref_clk);
    strb.ale <= 1'b0;
    @(posedge ref_clk);
    strb.rd_n <= !(kind == 2'h0 || kind == 2'h3);
    strb.wr_n <= kind != 2'h1;
    strb.psen_n <= kind != 2'h2;
    strb.inject_noop <= kind == 2'h3;
    // A released bus must not keep showing the address, so it carries its inverse
    ad_lo_in <= (kind == 2'h1) ? d : ~a[7:0];
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

// ===== testbench/test_board_address_decode.sv
// Self-checking bench for the address decode block.
// Assumes bad_decode and the processor model; APB master is driven here.
`timescale 1ns/10ps
`default_nettype none
module test_board_address_decode;
  logic        ref_clk, reset, psel, penable, pwrite, pready, pslverr, er;
  logic        ad_lo_oe, db_oe, sram_we_n, trap_space_sel_n, trap_ram_wr_n, boot_overlay_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  ad_lo_in, addr_hi, ad_lo_out, db_in, db_out, ram_seg_sel_n;
  logic [15:0] board_addr;
  logic [3:0]  rom_chip_sel_n;
  bad_pkg::bad_strobe_t strb;
  bad_pkg::bad_sel_t    sel;
  int          err_count, tests_run;
  int          cycles = 0;

  bad_decode u_dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .strb(strb),
    .ad_lo_in(ad_lo_in), .addr_hi(addr_hi), .ad_lo_out(ad_lo_out), .ad_lo_oe(ad_lo_oe), .db_in(db_in),
    .db_out(db_out), .db_oe(db_oe), .board_addr(board_addr), .sel(sel), .ram_seg_sel_n(ram_seg_sel_n),
    .rom_chip_sel_n(rom_chip_sel_n), .sram_we_n(sram_we_n), .trap_space_sel_n(trap_space_sel_n),
    .trap_ram_wr_n(trap_ram_wr_n), .boot_overlay_n(boot_overlay_n));
  bad_cpu_model u_cpu (.ref_clk(ref_clk), .strb(strb), .ad_lo_in(ad_lo_in), .addr_hi(addr_hi));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Ready and data are taken at the rising edge while the request still stands
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic acc(input logic [15:0] a, input logic [1:0] kind, input logic [7:0] d, input logic [8:0] es);
    u_cpu.cycle(a, kind, d);
    chk(sel, es);
    chk(board_addr, a);
  endtask

  task automatic t_reset;
    chk(boot_overlay_n, 1'b0);
    chk(sel, 9'h1FF);
    chk(ram_seg_sel_n, 8'hFF);
    apb(1'b0, bad_pkg::REG_MAP_CFG, 32'h0);
    chk(rd, bad_pkg::MAP_CFG_RESET);
    chk(er, 1'b0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    // Blocks 0,1,2 in spaces 0,2,3, trap space 0, 1K parts; no RAM/ROM mixing
    apb(1'b1, bad_pkg::REG_MAP_CFG, 32'h0000_7038);
    apb(1'b0, bad_pkg::REG_MAP_CFG, 32'h0);
    chk(rd, 32'h0000_7038);
  endtask

  task automatic t_overlay;
    acc(16'h0000, 2'h2, 8'h00, 9'h1EF);
    acc(16'hC000, 2'h1, 8'h11, 9'h1BF);
    chk(trap_ram_wr_n, 1'b0);
    chk(boot_overlay_n, 1'b1);
    acc(16'h0C00, 2'h0, 8'h00, 9'h1FB);
    chk(ram_seg_sel_n, 8'hF7);
    chk(trap_space_sel_n, 1'b0);
    chk(sram_we_n, 1'b1);
    chk(ad_lo_oe, 1'b1);
    chk(ad_lo_out, db_in);
    apb(1'b0, bad_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h0000_0009);
    apb(1'b0, bad_pkg::REG_LAST_ADDR, 32'h0);
    chk(rd, 32'h0000_0C00);
  endtask

  task automatic t_user;
    acc(16'h5400, 2'h1, 8'hA5, 9'h1FD);
    chk(ram_seg_sel_n, 8'hDF);
    chk(sram_we_n, 1'b0);
    chk(db_oe, 1'b1);
    chk(db_out, 8'hA5);
    chk(trap_space_sel_n, 1'b1);
    acc(16'h6800, 2'h0, 8'h00, 9'h1FE);
    chk(rom_chip_sel_n, 4'hB);
    acc(16'h6C00, 2'h2, 8'h00, 9'h1FE);
    chk(rom_chip_sel_n, 4'hF);
    apb(1'b1, bad_pkg::REG_MAP_CFG, 32'h0000_7238);
    acc(16'h7000, 2'h2, 8'h00, 9'h1FE);
    chk(rom_chip_sel_n, 4'hD);
    acc(16'h2000, 2'h0, 8'h00, 9'h1FF);
    acc(16'h8000, 2'h1, 8'h5A, 9'h1FF);
    acc(16'h9FFF, 2'h0, 8'h00, 9'h1FF);
  endtask

  task automatic t_nibbles;
    for (int n = 10; n < 16; n++) begin
      acc({n[3:0], 12'h123}, 2'h1, n[7:0], 9'h1FF ^ (9'h100 >> (n - 10)));
      chk(db_oe, n != 11);
    end
  endtask

  task automatic t_noop;
    acc(16'h0400, 2'h3, 8'h00, 9'h1FB);
    chk(ad_lo_out, bad_pkg::NOOP_OPCODE);
    chk(ad_lo_oe, 1'b1);
    chk(db_oe, 1'b0);
  endtask

  // Whole run needs well under 1000 cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    db_in = 8'h3C;
    err_count = 0;
    tests_run = 0;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    t_reset;
    t_overlay;
    t_user;
    t_nibbles;
    t_noop;
    wrap_up;
  end
endmodule
`default_nettype wire
